// ===== logic/rpd_params.svh
// Constants of the rear-panel digital I/O block
// Assumes a 100 MHz core clock and 32-bit AXI4-Lite register access
`ifndef RPD_PARAMS_SVH
`define RPD_PARAMS_SVH
// Clock and times
`define RPD_CLK_MHZ 100
`define RPD_STROBE_NS 1000
`define RPD_LONG_NS 10000
`define RPD_FILT_NS 1000
`define RPD_STROBE_CYC ((`RPD_STROBE_NS*`RPD_CLK_MHZ+999)/1000)
`define RPD_LONG_CYC ((`RPD_LONG_NS*`RPD_CLK_MHZ+999)/1000)
`define RPD_FILT_CYC ((`RPD_FILT_NS*`RPD_CLK_MHZ)/1000+1)
`define RPD_SWEEP_CYC 2000
// Register byte offsets
`define RPD_OFF_CTRL 8'h00
`define RPD_OFF_BUSCMD 8'h04
`define RPD_OFF_BUSDATA 8'h08
`define RPD_OFF_PORTAB 8'h0C
`define RPD_OFF_PORTCD 8'h10
`define RPD_OFF_GPIO 8'h14
`define RPD_OFF_PASSFAIL 8'h18
`define RPD_OFF_STATUS 8'h1C
// Field positions and codes
`define RPD_CTRL_ARM 0
`define RPD_CTRL_PFPOL 1
`define RPD_CTRL_TRIGPOL 2
`define RPD_CTRL_TRIGSRC 3
`define RPD_CTRL_FOOTSEL 4
`define RPD_BUSCMD_RNW 16
`define RPD_FOOT_ARM 2'h1
`define RPD_RESP_OKAY 2'h0
`define RPD_RESP_SLVERR 2'h2
`endif

// ===== logic/rpd_pkg.sv
// Types of the rear-panel digital I/O block
// Assumes the constants header for all figures
package rpd_pkg;
  typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_GAP, BUS_DATA, BUS_END} rpd_bus_t;
  typedef enum logic [1:0] {SW_IDLE, SW_ARMED, SW_RUN} rpd_swp_t;

  typedef struct packed {
    logic [12:0] muxBusOut;
    logic        muxBusOe;
    logic        unitSelectBit0;
    logic [1:0]  unitSelectBitsMid;
    logic        unitSelectBit3;
    logic        addrStrobeN;
    logic        dataStrobeN;
    logic        readNotWrite;
  } rpd_tset_t;

  typedef struct packed {
    logic [7:0] sorterPortA;
    logic [7:0] sorterPortB;
    logic [3:0] sorterPortCOut;
    logic [3:0] sorterPortCOe;
    logic [3:0] sorterPortDOut;
    logic [3:0] sorterPortDOe;
    logic       passFail;
    logic       passFailStrobeN;
    logic       sweepEndN;
    logic       portWriteStrobeN;
    logic       readyForTrigN;
    logic       trigOutConnector;
    logic [3:0] gpBidirOut;
    logic [3:0] gpBidirOe;
    logic       powerPress;
  } rpd_aux_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rpd_axi_t;

  typedef struct packed {
    logic [30:0] sync1;
    logic [30:0] sync2;
    rpd_tset_t   tset;
    rpd_aux_t    aux;
    rpd_axi_t    axi;
    logic        awGot;
    logic        wGot;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [4:0]  ctrl;
    logic [12:0] busAddr;
    logic        busRnw;
    logic        busStart;
    logic [12:0] busWrData;
    logic [12:0] busRdData;
    rpd_bus_t    busSt;
    logic [9:0]  busCnt;
    rpd_swp_t    swpSt;
    logic        armReq;
    logic [15:0] sweepCnt;
    logic [9:0]  endCnt;
    logic [9:0]  pwsCnt;
    logic [9:0]  pfCnt;
    logic [9:0]  toCnt;
    logic [9:0]  intrCnt;
    logic [9:0]  trigCnt;
    logic [9:0]  footCnt;
    logic        pfResult;
    logic [3:0]  sticky;
  } rpd_state_t;
endpackage

// ===== logic/rpd_top.sv
// Rear-panel digital I/O: test-set bus master, handler and aux ports
// Assumes one 100 MHz clock, AXI4-Lite master, pins resolved outside
// Contract
// - Drive 13-line test-set bus, strobes, interrupt; interrupt is only an input here, read to abort a sweep
// - Up to sixteen chained test sets
// - All four unit-select outputs held low
// - Address strobe low at least 1 us
// - Data strobe low at least 1 us
// - Read/write high for read, low write
// - Address first, then data, latched by receiver
// - No sweep start while hold-off low
// - Interrupt low 10 us aborts sweep
// - Two 8-bit outputs, two 4-bit bidirectional ports
// - Pass/fail strobe low at least 1 us
// - Latched pass/fail, selectable polarity
// - Sweep end low 10 us on completion
// - Port write strobe low 10 us
// - Ready-for-trigger low when trigger accepted; code drives it low while armed with hold-off high, high once the sweep runs
// - Level trigger, selectable polarity, over 1 us
// - Footswitch low over 1 us starts event
// - Power-button input low acts as press
// - Four general-purpose bidirectional lines
// - Both trigger inputs form one trigger
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rpd_params.svh"
module rpd_top (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output rpd_pkg::rpd_tset_t     tsetOut,
  input  wire logic [12:0]       muxBusIn,
  input  wire logic              holdoffN,
  input  wire logic              interruptN,
  output rpd_pkg::rpd_aux_t      auxOut,
  input  wire logic [3:0]        sorterPortCIn,
  input  wire logic [3:0]        sorterPortDIn,
  input  wire logic [3:0]        gpBidirIn,
  input  wire logic              extTrigIn,
  input  wire logic              trigInConnector,
  input  wire logic              footswitchN,
  input  wire logic              powerButtonN
);
  import rpd_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [9:0] satInc(input logic [9:0] c,
                                        input logic act,
                                        input logic [9:0] lim);
    satInc = !act ? 10'h000 : (c < lim) ? c + 10'h001 : c;
  endfunction

  function automatic logic [9:0] decr(input logic [9:0] c);
    decr = (c != 10'h000) ? c - 10'h001 : 10'h000;
  endfunction

  function automatic logic [31:0] bmerge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      bmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:5] == 3'h0);
  endfunction

  function automatic logic [31:0] regRd(input rpd_state_t s,
                                        input logic [7:0] a);
    case ({a[7:2], 2'h0})
      `RPD_OFF_CTRL: regRd = {26'h0, s.ctrl, 1'b0};
      `RPD_OFF_BUSCMD: regRd = {15'h0, s.busRnw, 3'h0, s.busAddr};
      `RPD_OFF_BUSDATA: regRd = {19'h0, s.busRdData};
      `RPD_OFF_PORTAB: regRd = {16'h0, s.aux.sorterPortB, s.aux.sorterPortA};
      `RPD_OFF_PORTCD: regRd = {16'h0, s.aux.sorterPortDOe, s.aux.sorterPortCOe,
                                s.aux.sorterPortDOut, s.aux.sorterPortCOut};
      `RPD_OFF_GPIO: regRd = {24'h0, s.aux.gpBidirOe, s.aux.gpBidirOut};
      `RPD_OFF_PASSFAIL: regRd = {31'h0, s.pfResult};
      `RPD_OFF_STATUS: regRd = {12'h0, s.sync2[30:19], s.sticky,
                                !s.sync2[0], s.swpSt == SW_ARMED,
                                s.swpSt == SW_RUN, s.busSt != BUS_IDLE};
      default: regRd = 32'h0;
    endcase
  endfunction

  // ==========================================================
  // State and synchronised inputs
  rpd_state_t st;
  rpd_state_t next_st;
  logic       holdN;
  logic       intrN;
  logic       trigA;
  logic       trigB;
  logic       footN;
  logic       pwrN;
  logic [12:0] busIn;
  logic       trigAct;
  logic       trigQual;
  logic       intrHit;
  logic       footHit;
  logic       doWr;
  logic [31:0] wv;
  logic [3:0] setSticky;
  logic [3:0] clrSticky;

  assign holdN = st.sync2[0];
  assign intrN = st.sync2[1];
  assign trigA = st.sync2[2];
  assign trigB = st.sync2[3];
  assign footN = st.sync2[4];
  assign pwrN  = st.sync2[5];
  assign busIn = st.sync2[18:6];

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    setSticky = 4'h0;
    clrSticky = 4'h0;
    wv = 32'h0;
    doWr = 1'b0;

    // Input synchronisers
    next_st.sync1 = {gpBidirIn, sorterPortDIn, sorterPortCIn, muxBusIn,
                     powerButtonN, footswitchN, trigInConnector,
                     extTrigIn, interruptN, holdoffN};
    next_st.sync2 = st.sync1;

    // Width filters
    trigAct = st.ctrl[`RPD_CTRL_TRIGPOL-1] ? (trigA | trigB)
                                           : !(trigA & trigB);
    next_st.trigCnt = satInc(st.trigCnt, trigAct, 10'(`RPD_FILT_CYC));
    trigQual = (st.trigCnt == 10'(`RPD_FILT_CYC));
    next_st.intrCnt = satInc(st.intrCnt, !intrN, 10'(`RPD_LONG_CYC));
    intrHit = (st.intrCnt == 10'(`RPD_LONG_CYC));
    next_st.footCnt = satInc(st.footCnt, !footN, 10'(`RPD_FILT_CYC));
    footHit = (next_st.footCnt == 10'(`RPD_FILT_CYC))
              && (st.footCnt != 10'(`RPD_FILT_CYC));
    next_st.aux.powerPress = !pwrN;
    setSticky[3] = !pwrN;
    setSticky[2] = footHit;

    // AXI write channel
    next_st.busStart = 1'b0;
    next_st.armReq = 1'b0;
    if (s_axi_awvalid && st.axi.awready) begin
      next_st.awAddr = s_axi_awaddr;
      next_st.awGot = 1'b1;
    end
    if (s_axi_wvalid && st.axi.wready) begin
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
      next_st.wGot = 1'b1;
    end
    if (st.axi.bvalid && s_axi_bready) begin
      next_st.axi.bvalid = 1'b0;
    end
    doWr = next_st.awGot && next_st.wGot && !next_st.axi.bvalid;
    if (doWr) begin
      next_st.awGot = 1'b0;
      next_st.wGot = 1'b0;
      next_st.axi.bvalid = 1'b1;
      next_st.axi.bresp = mapped(next_st.awAddr) ? `RPD_RESP_OKAY
                                                 : `RPD_RESP_SLVERR;
      wv = bmerge(regRd(st, next_st.awAddr), next_st.wData, next_st.wStrb);
      case ({next_st.awAddr[7:2], 2'h0})
        `RPD_OFF_CTRL: begin
          next_st.ctrl = wv[5:1];
          next_st.armReq = next_st.wStrb[0] && wv[`RPD_CTRL_ARM];
        end
        `RPD_OFF_BUSCMD: begin
          if (st.busSt == BUS_IDLE) begin
            next_st.busAddr = wv[12:0];
            next_st.busRnw = wv[`RPD_BUSCMD_RNW];
            next_st.busStart = 1'b1;
          end
        end
        `RPD_OFF_BUSDATA: next_st.busWrData = wv[12:0];
        `RPD_OFF_PORTAB: begin
          next_st.aux.sorterPortA = wv[7:0];
          next_st.aux.sorterPortB = wv[15:8];
          next_st.pwsCnt = 10'(`RPD_LONG_CYC);
        end
        `RPD_OFF_PORTCD: begin
          next_st.aux.sorterPortCOut = wv[3:0];
          next_st.aux.sorterPortDOut = wv[7:4];
          next_st.aux.sorterPortCOe = wv[11:8];
          next_st.aux.sorterPortDOe = wv[15:12];
        end
        `RPD_OFF_GPIO: begin
          next_st.aux.gpBidirOut = wv[3:0];
          next_st.aux.gpBidirOe = wv[7:4];
        end
        `RPD_OFF_PASSFAIL: begin
          next_st.pfResult = wv[0];
          next_st.pfCnt = 10'(`RPD_STROBE_CYC);
        end
        `RPD_OFF_STATUS: clrSticky = wv[7:4];
        default: ;
      endcase
    end
    next_st.axi.awready = !next_st.awGot && !next_st.axi.bvalid;
    next_st.axi.wready = !next_st.wGot && !next_st.axi.bvalid;

    // AXI read channel
    if (st.axi.rvalid && s_axi_rready) begin
      next_st.axi.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.axi.arready) begin
      next_st.axi.rvalid = 1'b1;
      next_st.axi.rdata = regRd(st, s_axi_araddr);
      next_st.axi.rresp = mapped(s_axi_araddr) ? `RPD_RESP_OKAY
                                               : `RPD_RESP_SLVERR;
    end
    next_st.axi.arready = !next_st.axi.rvalid;

    // Pass/fail latch with polarity
    next_st.aux.passFail = next_st.pfResult
                           ^ !next_st.ctrl[`RPD_CTRL_PFPOL-1];

    // Test-set bus master
    next_st.tset.unitSelectBit0 = 1'b0;
    next_st.tset.unitSelectBitsMid = 2'h0;
    next_st.tset.unitSelectBit3 = 1'b0;
    case (st.busSt)
      BUS_IDLE: begin
        next_st.tset.muxBusOe = 1'b0;
        if (st.busStart) begin
          next_st.tset.readNotWrite = st.busRnw;
          next_st.tset.muxBusOut = st.busAddr;
          next_st.tset.muxBusOe = 1'b1;
          next_st.tset.addrStrobeN = 1'b0;
          next_st.busCnt = 10'(`RPD_STROBE_CYC);
          next_st.busSt = BUS_ADDR;
        end
      end
      BUS_ADDR: begin
        next_st.busCnt = decr(st.busCnt);
        if (st.busCnt == 10'h001) begin
          next_st.tset.addrStrobeN = 1'b1;
          next_st.busSt = BUS_GAP;
        end
      end
      BUS_GAP: begin
        next_st.tset.muxBusOut = st.busWrData;
        next_st.tset.muxBusOe = !st.busRnw;
        next_st.tset.dataStrobeN = 1'b0;
        next_st.busCnt = 10'(`RPD_STROBE_CYC);
        next_st.busSt = BUS_DATA;
      end
      BUS_DATA: begin
        next_st.busCnt = decr(st.busCnt);
        if (st.busCnt == 10'h001) begin
          next_st.tset.dataStrobeN = 1'b1;
          if (st.busRnw) begin
            next_st.busRdData = busIn;
          end
          next_st.busSt = BUS_END;
        end
      end
      BUS_END: begin
        next_st.tset.muxBusOe = 1'b0;
        next_st.busSt = BUS_IDLE;
      end
      default: next_st.busSt = BUS_IDLE;
    endcase

    // Sweep sequencer
    case (st.swpSt)
      SW_IDLE: begin
        if (st.armReq || (footHit
            && st.ctrl[`RPD_CTRL_FOOTSEL-1 +: 2] == `RPD_FOOT_ARM)) begin
          next_st.swpSt = SW_ARMED;
        end
      end
      SW_ARMED: begin
        if (holdN && (!st.ctrl[`RPD_CTRL_TRIGSRC-1] || trigQual)) begin
          next_st.swpSt = SW_RUN;
          next_st.sweepCnt = 16'h0;
          next_st.toCnt = 10'(`RPD_STROBE_CYC);
        end
      end
      SW_RUN: begin
        next_st.sweepCnt = st.sweepCnt + 16'h1;
        if (intrHit) begin
          next_st.swpSt = SW_IDLE;
          setSticky[1] = 1'b1;
        end else if (st.sweepCnt == 16'(`RPD_SWEEP_CYC - 1)) begin
          next_st.swpSt = SW_IDLE;
          next_st.endCnt = 10'(`RPD_LONG_CYC);
          setSticky[0] = 1'b1;
        end
      end
      default: next_st.swpSt = SW_IDLE;
    endcase
    next_st.aux.readyForTrigN = !(next_st.swpSt == SW_ARMED && holdN);

    // Strobe timers
    if (doWr == 1'b0 || next_st.pwsCnt != 10'(`RPD_LONG_CYC)) begin
      next_st.pwsCnt = decr(next_st.pwsCnt);
    end
    if (next_st.pfCnt != 10'(`RPD_STROBE_CYC) || st.pfCnt == next_st.pfCnt) begin
      next_st.pfCnt = decr(next_st.pfCnt);
    end
    if (st.swpSt != SW_RUN || next_st.swpSt == SW_RUN) begin
      next_st.endCnt = decr(st.endCnt);
      next_st.toCnt = (st.swpSt == SW_ARMED) ? next_st.toCnt : decr(st.toCnt);
    end
    next_st.aux.portWriteStrobeN = (next_st.pwsCnt == 10'h000);
    next_st.aux.passFailStrobeN = (next_st.pfCnt == 10'h000);
    next_st.aux.sweepEndN = (next_st.endCnt == 10'h000);
    next_st.aux.trigOutConnector = (next_st.toCnt != 10'h000);

    // Sticky status, set wins over clear
    next_st.sticky = (st.sticky & ~clrSticky) | setSticky;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.sync1 <= 31'h0000_0033; // Active-low pins idle high
      st.sync2 <= 31'h0000_0033;
      st.tset.addrStrobeN <= 1'b1;
      st.tset.dataStrobeN <= 1'b1;
      st.aux.passFailStrobeN <= 1'b1;
      st.aux.sweepEndN <= 1'b1;
      st.aux.portWriteStrobeN <= 1'b1;
      st.aux.readyForTrigN <= 1'b1;
      st.aux.passFail <= 1'b1;
      st.axi.awready <= 1'b1;
      st.axi.wready <= 1'b1;
      st.axi.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign tsetOut = st.tset;
  assign auxOut = st.aux;
  assign s_axi_awready = st.axi.awready;
  assign s_axi_wready = st.axi.wready;
  assign s_axi_bvalid = st.axi.bvalid;
  assign s_axi_bresp = st.axi.bresp;
  assign s_axi_arready = st.axi.arready;
  assign s_axi_rvalid = st.axi.rvalid;
  assign s_axi_rdata = st.axi.rdata;
  assign s_axi_rresp = st.axi.rresp;
endmodule
`default_nettype wire

// ===== tb/rpd_top_asserts.sv
// Checker for the rear-panel digital I/O block
// Assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rpd_top_asserts (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire rpd_pkg::rpd_tset_t tsetOut,
  input wire rpd_pkg::rpd_aux_t  auxOut,
  input wire logic               powerButtonN
);
  import rpd_pkg::*;
  // ==========================================
  // Low-time counters of the five strobes
  logic [4:0]  strobeN;
  logic [10:0] lowCnt [5];
  assign strobeN = {auxOut.portWriteStrobeN, auxOut.sweepEndN, auxOut.passFailStrobeN,
                    tsetOut.dataStrobeN, tsetOut.addrStrobeN};
  always_ff @(posedge clk or negedge rst_n) begin
    for (int i = 0; i < 5; i++) begin
      if (!rst_n) lowCnt[i] <= 11'h000;
      else lowCnt[i] <= strobeN[i] ? 11'h000 : lowCnt[i] + 11'h001;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_select_low: assert property ({tsetOut.unitSelectBit0, tsetOut.unitSelectBitsMid,
    tsetOut.unitSelectBit3} == 4'h0) else $error("unit select not low");
  a_addr_width: assert property ($rose(strobeN[0]) |-> lowCnt[0] >= 11'h064)
    else $error("address strobe too short");
  a_data_width: assert property ($rose(strobeN[1]) |-> lowCnt[1] >= 11'h064)
    else $error("data strobe too short");
  a_pf_width: assert property ($rose(strobeN[2]) |-> lowCnt[2] >= 11'h064)
    else $error("pass/fail strobe too short");
  a_end_width: assert property ($rose(strobeN[3]) |-> lowCnt[3] >= 11'h3E8)
    else $error("sweep end too short");
  a_port_strobe_width: assert property ($rose(strobeN[4]) |-> lowCnt[4] >= 11'h3E8)
    else $error("port write strobe too short");
  a_no_overlap: assert property (tsetOut.addrStrobeN || tsetOut.dataStrobeN)
    else $error("strobes overlap");
  a_addr_first: assert property ($fell(tsetOut.dataStrobeN) |->
    $past(tsetOut.addrStrobeN, 2) == 1'b0 && tsetOut.addrStrobeN) else $error("no address phase");
  a_rnw_steady: assert property (!tsetOut.dataStrobeN |-> $stable(tsetOut.readNotWrite))
    else $error("read/write moved in data phase");
  a_addr_driven: assert property (!tsetOut.addrStrobeN |-> tsetOut.muxBusOe)
    else $error("address not driven");
  a_data_dir: assert property (!tsetOut.dataStrobeN |->
    tsetOut.muxBusOe == !tsetOut.readNotWrite) else $error("data direction wrong");
  a_power_follow: assert property ($fell(powerButtonN) |-> ##[1:4] auxOut.powerPress)
    else $error("power press missed");
  c_bus_read: cover property ($fell(tsetOut.addrStrobeN) && tsetOut.readNotWrite);
  c_bus_write: cover property ($fell(tsetOut.addrStrobeN) && !tsetOut.readNotWrite);
  c_sweep_end: cover property ($fell(auxOut.sweepEndN));
  c_port_write: cover property ($fell(auxOut.portWriteStrobeN));
endmodule
bind rpd_top rpd_top_asserts i_chk (.clk(clk), .rst_n(rst_n), .tsetOut(tsetOut),
  .auxOut(auxOut), .powerButtonN(powerButtonN));
`default_nettype wire

// ===== tb/rpd_top_tb_top.sv
// Self-checking bench for the rear-panel digital I/O block
// Assumes the design package, constants header and test-set model
`timescale 1ns/1ps
`default_nettype none
`include "rpd_params.svh"
module rpd_top_tb_top;
  import rpd_pkg::*;
  // ==========================================
  // Signals
  logic        clk = 1'b0, rst_n = 1'b0, flag;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  rpd_tset_t   tsetOut;
  rpd_aux_t    auxOut;
  logic [12:0] muxBusIn, gotAddr, gotData;
  logic        gotRnw;
  logic        holdoffN = 1'b1, interruptN = 1'b1, extTrigIn = 1'b0, trigInConnector = 1'b0;
  logic        footswitchN = 1'b1, powerButtonN = 1'b1;
  logic [3:0]  sorterPortCIn = 4'h9, sorterPortDIn = 4'h6, gpBidirIn = 4'hC;
  int          nMismatch = 0, nChecks = 0, cyc = 0;

  rpd_top i_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tsetOut, .muxBusIn, .holdoffN, .interruptN, .auxOut, .sorterPortCIn,
    .sorterPortDIn, .gpBidirIn, .extTrigIn, .trigInConnector, .footswitchN, .powerButtonN);
  rpd_tset_model i_tset (.clk, .tset(tsetOut), .readVal(13'h0F0F), .lineIn(muxBusIn),
    .gotAddr, .gotData, .gotRnw);

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      endSim();
    end
  end
  // ==========================================
  // Common tasks
  task automatic endSim();
    if (nMismatch == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pollIdle();
    repeat (2) @(posedge clk);
    do rdReg(`RPD_OFF_STATUS); while (rd[0] !== 1'b0);
  endtask
  // ==========================================
  // Scenarios
  task automatic tReset();
    chk({tsetOut.addrStrobeN, tsetOut.dataStrobeN, tsetOut.muxBusOe}, 3'h6);
    chk({tsetOut.unitSelectBit0, tsetOut.unitSelectBitsMid, tsetOut.unitSelectBit3}, 0);
  endtask
  task automatic tBus();
    wr(`RPD_OFF_BUSDATA, 32'h0000_1A5A);
    wr(`RPD_OFF_BUSCMD, 32'h0000_1234);
    pollIdle();
    chk({gotRnw, gotAddr, gotData}, {1'b0, 13'h1234, 13'h1A5A});
    wr(`RPD_OFF_BUSCMD, 32'h0001_0ABC);
    pollIdle();
    chk({gotRnw, gotAddr}, {1'b1, 13'h0ABC});
    rdReg(`RPD_OFF_BUSDATA);
    chk(rd, 32'h0000_0F0F);
  endtask
  task automatic tPorts();
    wr(`RPD_OFF_PORTAB, 32'h0000_A55A);
    repeat (2) @(posedge clk);
    chk({auxOut.sorterPortB, auxOut.sorterPortA, auxOut.portWriteStrobeN}, 17'h14AB4);
    wr(`RPD_OFF_PORTCD, 32'h0000_C3A5);
    wr(`RPD_OFF_GPIO, 32'h0000_005A);
    repeat (2) @(posedge clk);
    chk({auxOut.sorterPortDOe, auxOut.sorterPortCOe, auxOut.sorterPortDOut,
         auxOut.sorterPortCOut}, 16'hC3A5);
    chk({auxOut.gpBidirOe, auxOut.gpBidirOut}, 8'h5A);
    rdReg(`RPD_OFF_STATUS);
    chk(rd[19:8], 12'hC69);
    rdReg(8'h20);
    chk({rr, rd}, {`RPD_RESP_SLVERR, 32'h0000_0000});
    wr(8'h24, 32'h0000_0001);
    chk(rr, `RPD_RESP_SLVERR);
  endtask
  task automatic tPassFail();
    wr(`RPD_OFF_CTRL, 32'h0000_0002);
    wr(`RPD_OFF_PASSFAIL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({auxOut.passFail, auxOut.passFailStrobeN}, 2'h2);
    wr(`RPD_OFF_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(auxOut.passFail, 1'b0);
  endtask
  task automatic tSweep();
    @(posedge clk) holdoffN <= 1'b0;
    wr(`RPD_OFF_CTRL, 32'h0000_000D);
    repeat (300) @(posedge clk);
    rdReg(`RPD_OFF_STATUS);
    chk({auxOut.readyForTrigN, rd[2:1]}, 3'h6);
    @(posedge clk) holdoffN <= 1'b1;
    repeat (5) @(posedge clk);
    chk(auxOut.readyForTrigN, 1'b0);
    @(posedge clk) extTrigIn <= 1'b1;
    repeat (50) @(posedge clk);
    extTrigIn <= 1'b0;
    repeat (20) @(posedge clk);
    rdReg(`RPD_OFF_STATUS);
    chk(rd[1], 1'b0);
    @(posedge clk) trigInConnector <= 1'b1;
    repeat (150) @(posedge clk);
    trigInConnector <= 1'b0;
    rdReg(`RPD_OFF_STATUS);
    chk(rd[1], 1'b1);
    for (int i = 0; i < 3000 && auxOut.sweepEndN; i++) @(posedge clk);
    rdReg(`RPD_OFF_STATUS);
    chk({auxOut.sweepEndN, rd[4]}, 2'h1);
    wr(`RPD_OFF_STATUS, 32'h0000_00FF);
  endtask
  task automatic tAbort();
    wr(`RPD_OFF_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(auxOut.trigOutConnector, 1'b1);
    @(posedge clk) interruptN <= 1'b0;
    repeat (500) @(posedge clk);
    interruptN <= 1'b1;
    rdReg(`RPD_OFF_STATUS);
    chk(rd[5:4], 2'h0);
    @(posedge clk) interruptN <= 1'b0;
    repeat (1100) @(posedge clk);
    interruptN <= 1'b1;
    flag = 1'b0;
    for (int i = 0; i < 1500; i++) begin
      @(posedge clk);
      flag |= !auxOut.sweepEndN;
    end
    rdReg(`RPD_OFF_STATUS);
    chk({flag, rd[5:4]}, 3'h2);
    wr(`RPD_OFF_STATUS, 32'h0000_00FF);
  endtask
  task automatic tFoot();
    wr(`RPD_OFF_CTRL, 32'h0000_0010);
    @(posedge clk) footswitchN <= 1'b0;
    repeat (150) @(posedge clk);
    footswitchN <= 1'b1;
    repeat (10) @(posedge clk);
    powerButtonN <= 1'b0;
    repeat (10) @(posedge clk);
    rdReg(`RPD_OFF_STATUS);
    chk({rd[6], rd[1]}, 2'h3);
    chk({auxOut.powerPress, rd[7]}, 2'h3);
    @(posedge clk) powerButtonN <= 1'b1;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tReset();
    tBus();
    tPorts();
    tPassFail();
    tSweep();
    tAbort();
    tFoot();
    endSim();
  end
endmodule
`default_nettype wire

// ===== tb/rpd_tset_model.sv
// External test-set model on the shared address/data lines
// Assumes no pull-ups: released lines show a changing pattern
`timescale 1ns/1ps
`default_nettype none
module rpd_tset_model (
  input wire logic               clk,
  input wire rpd_pkg::rpd_tset_t tset,
  input wire logic [12:0]        readVal,
  output logic [12:0]            lineIn,
  output logic [12:0]            gotAddr,
  output logic [12:0]            gotData,
  output logic                   gotRnw
);
  import rpd_pkg::*;
  logic [12:0] last = 13'h0000;
  // ==========================================
  // Line level and latches
  always_comb begin
    if (tset.muxBusOe) lineIn = tset.muxBusOut;
    else if (tset.readNotWrite && !tset.dataStrobeN) lineIn = readVal;
    else lineIn = ~last;
  end
  always_ff @(posedge clk) begin
    last <= lineIn;
    if (!tset.addrStrobeN) begin
      gotAddr <= lineIn;
      gotRnw <= tset.readNotWrite;
    end
    if (!tset.dataStrobeN && !tset.readNotWrite) gotData <= lineIn;
  end
endmodule
`default_nettype wire
